// >>> acs_pkg.sv
package acs_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [31:0] MODE_A_OFS   = 32'h0000_0000;
    localparam logic [31:0] MODE_B_OFS   = 32'h0000_0004;
    localparam logic [31:0] IRQ_STS_OFS  = 32'h0000_0008;
    localparam logic [31:0] IRQ_MSK_OFS  = 32'h0000_000C;
    localparam logic [31:0] RESULT0_OFS  = 32'h0000_0010;
    localparam logic [31:0] RESULT3_OFS  = 32'h0000_001C;

    // Field positions in conv_mode_reg_a.
    localparam int CE_BIT = 7;
    localparam int CS_BIT = 6;

    // Values after reset, and the first trial code of a conversion.
    localparam logic [7:0] MODE_A_RST = 8'h00;
    localparam logic [7:0] MODE_B_RST = 8'h00;
    localparam logic [9:0] RESULT_RST = 10'h000;
    localparam logic [9:0] SAR_FIRST  = 10'h200;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing.
    localparam int CLK_PERIOD_NS  = 10;
    localparam int BIT_SETTLE_NS  = 40;
    localparam int BIT_SETTLE_CYC = (BIT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES    = 2;
    localparam logic [3:0] DECIDE_CYC = 4'(BIT_SETTLE_CYC + SYNC_STAGES - 1);
    localparam logic [1:0] CS_DELAY   = 2'h3;
    localparam logic [3:0] LAST_BIT   = 4'h9;

    typedef enum logic [1:0] {
        TRIG_INT  = 2'h0,
        TRIG_TMR1 = 2'h1,
        TRIG_TMR4 = 2'h3,
        TRIG_BAD  = 2'h2
    } acs_trig_e;

    typedef enum logic [1:0] {
        OP_SEL1 = 2'h0,
        OP_SEL4 = 2'h1,
        OP_SCAN = 2'h3,
        OP_BAD  = 2'h2
    } acs_op_e;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'h0,
        ST_STANDBY = 2'h1,
        ST_LAUNCH  = 2'h3,
        ST_CONVERT = 2'h2
    } acs_fsm_e;

    typedef struct packed {
        logic start;
        logic abort;
    } acs_sar_ctl_s;

    typedef struct packed {
        logic       busy;
        logic       done;
        logic [9:0] code;
    } acs_sar_out_s;

    function automatic acs_trig_e trig_of(input logic [7:0] b);
        acs_trig_e t;
        t = TRIG_BAD;
        if (b[7:5] == 3'h0 && !b[3]) begin
            t = TRIG_INT;
        end else if (b[7:3] == 5'h04) begin
            t = TRIG_TMR1;
        end else if (b[7:3] == 5'h06) begin
            t = TRIG_TMR4;
        end
        return t;
    endfunction

    function automatic acs_op_e op_of(input logic [7:0] a);
        acs_op_e o;
        o = OP_BAD;
        if (a[5:2] == 4'h4) begin
            o = OP_SEL1;
        end else if (a[5:2] == 4'hC) begin
            o = OP_SEL4;
        end else if (a[4:2] == 3'h0) begin
            o = OP_SCAN;
        end
        return o;
    endfunction

endpackage

// >>> acs_sar_core.sv
`timescale 1ns/100ps
module acs_sar_core (
    // Clock and reset.
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    // Sequencer side.
    input  wire acs_pkg::acs_sar_ctl_s ctl,
    output acs_pkg::acs_sar_out_s      sar,
    // Comparator from the analog front end.
    input  wire logic                  comp_hi_async
);

    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       busy;
        logic       done;
        logic [3:0] bitn;
        logic [3:0] wait_cnt;
        logic [9:0] code;
    } acs_core_s;

    acs_core_s q;
    acs_core_s d;

    always_comb begin
        d       = q;
        d.sync1 = comp_hi_async;
        d.sync2 = q.sync1;
        d.done  = 1'b0;
        if (ctl.abort) begin
            d.busy = 1'b0;
        end else if (ctl.start) begin
            d.busy     = 1'b1;
            d.bitn     = acs_pkg::LAST_BIT;
            d.wait_cnt = 4'h0;
            d.code     = acs_pkg::SAR_FIRST;
        end else if (q.busy) begin
            // The comparator is judged only after the tap settled and the sync lag passed.
            if (q.wait_cnt == acs_pkg::DECIDE_CYC) begin
                d.wait_cnt = 4'h0;
                // (R3) Successive bit decision.
                if (!q.sync2) begin
                    d.code[q.bitn] = 1'b0;
                end
                if (q.bitn == 4'h0) begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                end else begin
                    d.bitn                = q.bitn - 4'h1;
                    d.code[q.bitn - 4'h1] = 1'b1;
                end
            end else begin
                d.wait_cnt = q.wait_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sar.busy = q.busy;
    assign sar.done = q.done;
    assign sar.code = q.code;

endmodule

// >>> acs_sequencer.sv
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
// Summary of operation
// (R1) Setting enable starts at once internally; timer trigger mode waits in standby.
// (R2) Timer mode converts only on a trigger, then returns to standby.
// (R3) Ten bits resolved one by one; result stored only after the last bit.
// (R4) Mode register write mid-conversion abandons it without storing a result.
// (R5) Register b bits select internal, one-trigger or four-trigger timer mode.
// (R6) Register a bits select one-buffer, four-buffer select or scan mode.
// (R7) Start events are match pulses of four compare channels of a timer.
// (R8) One-trigger mode takes channel 0 only; four-trigger mode takes all four.
// (R9) Select one-buffer stores in the input's own register; interrupt each conversion.
// (R10) Select four-buffer fills registers 0 to 3; interrupt after the fourth.
// (R11) Scan converts inputs upward from 0; interrupt when all are done.
// (R12) Scan's highest input comes from the input select field.
// (R13) Internal select one-buffer stops after one conversion and its interrupt.
// (R14) Internal mode restarts a sequence when software writes enable as one.
// (R15) Active status reads one three clocks after start; writes ignored.
// (R16) Result reads give ten bits low, upper bits zero.
// (R17) Triggers outside standby are ignored; results only from complete conversions.
// (R18) After reset enable is clear, sequencer idle, no conversion or interrupt.
module acs_sequencer (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // AXI4-Lite write address and data.
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response.
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read.
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Compare channel match pulses.
    input  wire logic [3:0]  trig_match,
    // Analog front end.
    input  wire logic        comp_hi_async,
    output logic [1:0]       mux_sel,
    output logic [9:0]       dac_code,
    output logic             sample_hold,
    // Interrupt.
    output logic             conv_done_irq
);

    typedef struct packed {
        logic                  aw_held;
        logic [31:0]           aw_addr;
        logic                  w_held;
        logic [7:0]            w_data;
        logic                  w_strb0;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic [7:0]            mode_a;
        logic [7:0]            mode_b;
        logic                  done_sts;
        logic                  done_msk;
        logic [3:0][9:0]       result;
        acs_pkg::acs_fsm_e     fsm;
        logic [1:0]            idx;
        logic [1:0]            tch;
        logic [1:0]            dest;
        logic [1:0]            mux;
        logic [1:0]            cs_cnt;
    } acs_state_s;

    acs_state_s            q;
    acs_state_s            d;
    acs_pkg::acs_sar_ctl_s sar_ctl;
    acs_pkg::acs_sar_out_s sar;
    acs_pkg::acs_trig_e    trig;
    acs_pkg::acs_op_e      op;
    acs_pkg::acs_trig_e    new_trig;
    acs_pkg::acs_op_e      new_op;
    logic                  wr_fire;
    logic                  wr_map;
    logic                  mode_wr;
    logic                  cs_bit;
    logic [1:0]            last_idx;
    logic                  trig_hit;
    logic [1:0]            trig_ch;
    logic [31:0]           rd_data;
    logic                  rd_map;

    acs_sar_core u_sar (
        .ref_clk       (ref_clk),
        .arst_n        (arst_n),
        .ctl           (sar_ctl),
        .sar           (sar),
        .comp_hi_async (comp_hi_async)
    );

    // (R15) Active status delay.
    assign cs_bit = (q.cs_cnt == acs_pkg::CS_DELAY);

    // (R5) Trigger decode.
    assign trig = acs_pkg::trig_of(q.mode_b);
    // (R6) Operation decode.
    assign op   = acs_pkg::op_of(q.mode_a);

    // (R12) Scan length from select.
    always_comb begin
        unique case (op)
            acs_pkg::OP_SEL4: last_idx = 2'h3;
            acs_pkg::OP_SCAN: last_idx = q.mode_a[1:0];
            default:          last_idx = 2'h0;
        endcase
    end

    // (R8) Accepted start channels.
    always_comb begin
        trig_ch  = 2'h0;
        trig_hit = 1'b0;
        if (trig == acs_pkg::TRIG_TMR1) begin
            trig_hit = trig_match[0];
        end else if (trig == acs_pkg::TRIG_TMR4) begin
            trig_hit = |trig_match;
            for (int i = 3; i >= 0; i--) begin
                if (trig_match[i]) begin
                    trig_ch = 2'(i);
                end
            end
        end
    end

    assign wr_fire = q.aw_held && q.w_held && !q.bvalid;
    assign wr_map  = (q.aw_addr[31:5] == 27'h0) && (q.aw_addr[1:0] == 2'h0);
    assign mode_wr = wr_fire && wr_map && q.w_strb0 &&
                     (q.aw_addr == acs_pkg::MODE_A_OFS || q.aw_addr == acs_pkg::MODE_B_OFS);

    always_comb begin
        rd_map  = (s_axi_araddr[31:5] == 27'h0) && (s_axi_araddr[1:0] == 2'h0);
        rd_data = 32'h0000_0000;
        // (R16) Results zero-extended.
        if (s_axi_araddr[4]) begin
            rd_data = {22'h000000, q.result[s_axi_araddr[3:2]]};
        end else begin
            unique case (s_axi_araddr[3:2])
                2'h0: rd_data = {24'h000000, q.mode_a[7], cs_bit, q.mode_a[5:0]};
                2'h1: rd_data = {24'h000000, q.mode_b};
                2'h2: rd_data = {31'h00000000, q.done_sts};
                2'h3: rd_data = {31'h00000000, q.done_msk};
            endcase
        end
    end

    always_comb begin
        d             = q;
        sar_ctl.start = 1'b0;
        sar_ctl.abort = mode_wr;
        new_trig      = acs_pkg::TRIG_BAD;
        new_op        = acs_pkg::OP_BAD;

        if (s_axi_awvalid && !q.aw_held) begin
            d.aw_held = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_held) begin
            d.w_held  = 1'b1;
            d.w_data  = s_axi_wdata[7:0];
            d.w_strb0 = s_axi_wstrb[0];
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (wr_fire) begin
            d.aw_held = 1'b0;
            d.w_held  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = wr_map ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
            if (wr_map && q.w_strb0) begin
                unique case (q.aw_addr[4:0])
                    // (R15) Status bit not writable.
                    5'h00: d.mode_a = {q.w_data[7], 1'b0, q.w_data[5:0]};
                    5'h04: d.mode_b = q.w_data;
                    5'h08: d.done_sts = q.done_sts & ~q.w_data[0];
                    5'h0C: d.done_msk = q.w_data[0];
                    default: d.done_msk = q.done_msk;
                endcase
            end
        end

        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rdata  = rd_map ? rd_data : 32'h0000_0000;
            d.rresp  = rd_map ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
        end

        if (mode_wr) begin
            // (R4) Abandon and restart.
            new_trig = acs_pkg::trig_of(d.mode_b);
            new_op   = acs_pkg::op_of(d.mode_a);
            d.idx    = 2'h0;
            d.fsm    = acs_pkg::ST_IDLE;
            if (d.mode_a[acs_pkg::CE_BIT] && new_trig != acs_pkg::TRIG_BAD &&
                new_op != acs_pkg::OP_BAD) begin
                // (R1) Start or standby.
                // (R14) Enable write restarts.
                d.fsm = (new_trig == acs_pkg::TRIG_INT) ? acs_pkg::ST_LAUNCH
                                                        : acs_pkg::ST_STANDBY;
            end
        end else begin
            unique case (q.fsm)
                acs_pkg::ST_IDLE: begin
                    d.fsm = acs_pkg::ST_IDLE;
                end
                acs_pkg::ST_STANDBY: begin
                    // (R2) Trigger starts conversion.
                    // (R17) Only standby sees triggers.
                    // (R7) Timer match pulses.
                    if (trig_hit) begin
                        d.tch = trig_ch;
                        d.fsm = acs_pkg::ST_LAUNCH;
                    end
                end
                acs_pkg::ST_LAUNCH: begin
                    sar_ctl.start = 1'b1;
                    d.fsm         = acs_pkg::ST_CONVERT;
                    // (R11) Scan walks inputs upward.
                    d.mux = (op == acs_pkg::OP_SCAN) ? q.idx : q.mode_a[1:0];
                    if (op == acs_pkg::OP_SEL1) begin
                        // (R9) Own result register.
                        d.dest = q.mode_a[1:0];
                    end else if (op == acs_pkg::OP_SEL4 && trig == acs_pkg::TRIG_TMR4) begin
                        d.dest = q.tch;
                    end else begin
                        // (R10) Registers in turn.
                        d.dest = q.idx;
                    end
                end
                acs_pkg::ST_CONVERT: begin
                    if (sar.done) begin
                        // (R3) Store after last bit.
                        d.result[q.dest] = sar.code;
                        if (q.idx == last_idx) begin
                            // (R10) Interrupt at sequence end.
                            d.done_sts = 1'b1;
                            d.idx      = 2'h0;
                        end else begin
                            d.idx = q.idx + 2'h1;
                        end
                        if (trig != acs_pkg::TRIG_INT) begin
                            // (R2) Back to standby.
                            d.fsm = acs_pkg::ST_STANDBY;
                        end else if (q.idx == last_idx) begin
                            // (R13) Stop after sequence.
                            d.fsm = acs_pkg::ST_IDLE;
                        end else begin
                            d.fsm = acs_pkg::ST_LAUNCH;
                        end
                    end
                end
            endcase
        end

        if (d.fsm == acs_pkg::ST_LAUNCH || d.fsm == acs_pkg::ST_CONVERT) begin
            if (q.cs_cnt != acs_pkg::CS_DELAY) begin
                d.cs_cnt = q.cs_cnt + 2'h1;
            end
        end else begin
            d.cs_cnt = 2'h0;
        end
    end

    // (R18) Reset to idle, enable clear.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q        <= '0;
            q.mode_a <= acs_pkg::MODE_A_RST;
            q.mode_b <= acs_pkg::MODE_B_RST;
            q.result <= {4{acs_pkg::RESULT_RST}};
            q.fsm    <= acs_pkg::ST_IDLE;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = !q.aw_held;
    assign s_axi_wready  = !q.w_held;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign mux_sel       = q.mux;
    assign dac_code      = sar.code;
    assign sample_hold   = sar.busy;
    assign conv_done_irq = q.done_sts & q.done_msk;

endmodule

// >>> acs_afe_model.sv
`timescale 1ns/100ps
// Comparator stand-in: each input holds a fixed level, so a correct search lands on it exactly.
module acs_afe_model #(
    parameter logic [3:0][9:0] LVL = {10'h001, 10'h15A, 10'h2A5, 10'h3FF}
) (
    // Converter side.
    input  wire logic [1:0] mux_sel,
    input  wire logic [9:0] dac_code,
    // Inverts every level so a repeat conversion gives a new code.
    input  wire logic       flip,
    output logic            comp_hi_async
);
    logic [9:0] level;

    assign level = LVL[mux_sel] ^ {10{flip}};
    assign comp_hi_async = level >= dac_code;
endmodule

// >>> acs_sequencer_sva.sv
`timescale 1ns/100ps
module acs_sequencer_sva (
    // Clock and reset.
    input wire logic        ref_clk,
    input wire logic        arst_n,
    // Register bus.
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // Converter side.
    input wire logic [3:0]  trig_match,
    input wire logic        sample_hold,
    input wire logic        conv_done_irq
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    logic [31:0] ar_q;
    logic        wr_seen_q;

    // Read data is judged against the address that was taken for it.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ar_q      <= 32'h0;
            wr_seen_q <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                ar_q <= s_axi_araddr;
            end
            if (s_axi_bvalid) begin
                wr_seen_q <= 1'b1;
            end
        end
    end

    chk_idle_reset: assert property (!wr_seen_q && !s_axi_bvalid |->
        !sample_hold && !conv_done_irq) else $error("converter active before any write");
    // interrupt cause.
    // A mask write raises the line at the edge that raises the write response.
    chk_irq_cause: assert property ($rose(conv_done_irq) |-> $past(sample_hold) ||
        $past(sample_hold, 2) || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("interrupt rose without a conversion end or write");
    chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    chk_result_upper: assert property (s_axi_rvalid && ar_q >= acs_pkg::RESULT0_OFS
        && ar_q <= acs_pkg::RESULT3_OFS |-> s_axi_rdata[31:10] == 22'h0)
        else $error("result read with upper bits set");
    chk_unmapped_err: assert property (s_axi_rvalid && ar_q > acs_pkg::RESULT3_OFS |->
        s_axi_rresp == acs_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_cs_idle: assert property (s_axi_rvalid && ar_q == acs_pkg::MODE_A_OFS
        && !s_axi_rdata[acs_pkg::CE_BIT] |-> !s_axi_rdata[acs_pkg::CS_BIT])
        else $error("active status set while disabled");

    cov_irq: cover property ($rose(conv_done_irq));
    cov_trig: cover property (|trig_match ##[1:3] $rose(sample_hold));
    cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == acs_pkg::RESP_SLVERR);
endmodule

bind acs_sequencer acs_sequencer_sva u_acs_sequencer_sva (
    .ref_clk(ref_clk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .trig_match(trig_match), .sample_hold(sample_hold),
    .conv_done_irq(conv_done_irq)
);

// >>> test_adc_conversion_sequencer.sv
`timescale 1ns/100ps
module test_adc_conversion_sequencer;
    localparam logic [3:0][9:0] LV = {10'h001, 10'h15A, 10'h2A5, 10'h3FF};
    localparam logic [31:0] MA  = acs_pkg::MODE_A_OFS;
    localparam logic [31:0] MB  = acs_pkg::MODE_B_OFS;
    localparam logic [31:0] STS = acs_pkg::IRQ_STS_OFS;
    localparam logic [31:0] MSK = acs_pkg::IRQ_MSK_OFS;
    localparam logic [31:0] RES = acs_pkg::RESULT0_OFS;

    logic        clk, arst_n, awv, aw_rdy, wv, w_rdy, bv, br, arv, ar_rdy, rv, rr;
    logic        comp, hold, irq, flip;
    logic [31:0] aw_a, wd, ar_a, rdata;
    logic [1:0]  rresp, bresp, mux;
    logic [3:0]  trig;
    logic [9:0]  dac;
    logic [31:0] rsp;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cyc;

    acs_sequencer u_acs_sequencer (
        .ref_clk(clk), .arst_n(arst_n), .s_axi_awvalid(awv), .s_axi_awready(aw_rdy),
        .s_axi_awaddr(aw_a), .s_axi_wvalid(wv), .s_axi_wready(w_rdy), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(ar_rdy), .s_axi_araddr(ar_a), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .trig_match(trig),
        .comp_hi_async(comp), .mux_sel(mux), .dac_code(dac), .sample_hold(hold),
        .conv_done_irq(irq)
    );

    acs_afe_model #(.LVL(LV)) u_acs_afe_model (
        .mux_sel(mux), .dac_code(dac), .flip(flip), .comp_hi_async(comp)
    );

    function automatic logic [31:0] lv(input int i, input logic f);
        return {22'h0, LV[i] ^ {10{f}}};
    endfunction

    task automatic stop_test;
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        int n;
        n = 0;
        aw_a <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk);
            if (aw_rdy && awv) awv <= 1'b0;
            if (w_rdy && wv) wv <= 1'b0;
            n++;
        end while (bv !== 1'b1 && n < 40);
        // Ready stays up between calls, so no time step drives it twice.
        chk({29'h0, bv, bresp}, {29'h0, 1'b1, acs_pkg::RESP_OKAY});
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        int n;
        n = 0;
        ar_a <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clk);
            if (ar_rdy) arv <= 1'b0;
            n++;
        end while (rv !== 1'b1 && n < 40);
        rsp = {30'h0, rresp};
        chk(rv, 1'b1);
        chk(rdata, exp);
    endtask

    task automatic wait_irq(output int n);
        n = 0;
        while (irq !== 1'b1 && n < 900) begin
            @(posedge clk);
            n++;
        end
        chk(irq, 1'b1);
    endtask

    // A conversion that never starts leaves the count short and is caught.
    task automatic wait_conv;
        int n;
        n = 0;
        while (hold !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        while (hold === 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk(n > 40 && n < 200, 1'b1);
    endtask

    task automatic pulse(input logic [3:0] m);
        trig <= m;
        @(posedge clk);
        trig <= 4'h0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        idle(20000);
        mismatches++;
        stop_test;
    end

    initial begin
        {awv, wv, br, arv, rr, flip} = 6'h00;
        {aw_a, wd, ar_a} = 96'h0;
        trig = 4'h0;
        arst_n = 1'b0;
        idle(3);
        arst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++) rdc(32'(4 * i), 32'h0);
        chk(irq, 1'b0);
        rdc(32'h20, 32'h0);
        chk(rsp, {30'h0, acs_pkg::RESP_SLVERR});
        wr(RES, 8'h55);
        rdc(RES, 32'h0);
        // Masked: status sets, line stays low until the mask opens.
        wr(MA, 8'h91);
        idle(5);
        rdc(MA, 32'hD1);
        wait_conv;
        chk(irq, 1'b0);
        rdc(STS, 32'h1);
        rdc(RES + 4, lv(1, 0));
        rdc(RES, 32'h0);
        rdc(MA, 32'h91);
        wr(MSK, 8'h01);
        chk(irq, 1'b1);
        wr(STS, 8'h01);
        chk(irq, 1'b0);
        idle(100);
        chk(hold, 1'b0);
        flip <= 1'b1;
        wr(MA, 8'h91);
        wait_irq(cyc);
        rdc(RES + 4, lv(1, 1));
        wr(STS, 8'h01);
        wr(MA, 8'hB3);
        wait_irq(cyc);
        chk(cyc > 200, 1'b1);
        for (int i = 0; i < 4; i++) rdc(RES + 4 * i, lv(3, 1));
        wr(STS, 8'h01);
        flip <= 1'b0;
        wr(MA, 8'h82);
        wait_irq(cyc);
        for (int i = 0; i < 4; i++) rdc(RES + 4 * i, lv(i < 3 ? i : 3, i == 3));
        wr(STS, 8'h01);
        flip <= 1'b1;
        wr(MA, 8'h90);
        idle(20);
        wr(MA, 8'h50);
        idle(100);
        chk(irq, 1'b0);
        rdc(RES, lv(0, 0));
        rdc(MA, 32'h10);
        wr(MB, 8'h20);
        wr(MA, 8'h92);
        idle(20);
        chk(hold, 1'b0);
        pulse(4'h2);
        idle(20);
        chk(hold, 1'b0);
        pulse(4'h1);
        wait_irq(cyc);
        rdc(RES + 8, lv(2, 1));
        wr(STS, 8'h01);
        flip <= 1'b0;
        pulse(4'h1);
        idle(10);
        pulse(4'h1);
        wait_irq(cyc);
        rdc(RES + 8, lv(2, 0));
        wr(STS, 8'h01);
        idle(80);
        chk(irq, 1'b0);
        wr(MB, 8'h30);
        wr(MA, 8'hB0);
        for (int i = 3; i >= 0; i--) begin
            flip <= i[0];
            pulse(4'(1 << i));
            chk(irq, 1'b0);
            wait_conv;
        end
        idle(1);
        chk(irq, 1'b1);
        for (int i = 0; i < 4; i++) rdc(RES + 4 * i, lv(0, i[0]));
        stop_test;
    end
endmodule
